// *** bench/oss_seq_properties.sv ***
// Port checker of the oscillator switch sequencer.
`default_nettype none
module oss_seq_props #(
   parameter [10:0] NEW_CLK_CYCLES = 11'h00a
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic switchMonitorCfg,
   input wire logic pllLock,
   input wire logic newClkTick,
   input wire logic [3:0] oscEnable,
   input wire logic pllEnable,
   input wire logic [2:0] sysClkSel,
   input wire logic switchBusy,
   input wire logic irq
);
   logic [7:0] tickCnt;
   logic tgtOn;
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   // Ticks seen since the sequencer left idle; an upper bound of its count.
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         tickCnt <= 8'h00;
      end else if (!switchBusy) begin
         tickCnt <= 8'h00;
      end else if (newClkTick && tickCnt != 8'hff) begin
         tickCnt <= tickCnt + 8'h01;
      end
   end
   always @* begin
      case (sysClkSel)
         3'h2, 3'h3: tgtOn = oscEnable[0];
         3'h4: tgtOn = oscEnable[1];
         3'h5: tgtOn = oscEnable[3];
         default: tgtOn = oscEnable[2];
      endcase
   end
   a_ready_pulse: assert property (pready |=> !pready)
      else $error("pready longer than one cycle");
   a_ready_wait: assert property (psel && penable && !pready |=> pready)
      else $error("access phase not answered");
   a_unmapped_err: assert property (pready && !pwrite && paddr > 12'h014
      |-> pslverr && prdata == 32'h0) else $error("unmapped read accepted");
   a_disabled_idle: assert property (switchMonitorCfg && !switchBusy
      |=> !switchBusy) else $error("switch started while disabled");
   a_pll_locked: assert property ($changed(sysClkSel) &&
      (sysClkSel == 3'h1 || sysClkSel == 3'h3) |-> pllEnable && $past(pllLock))
      else $error("PLL source taken without lock");
   a_target_on: assert property ($changed(sysClkSel) |-> tgtOn)
      else $error("new source not powered");
   a_ten_ticks: assert property ($changed(sysClkSel)
      |-> {3'b000, tickCnt} >= NEW_CLK_CYCLES) else $error("too few ticks");
   a_busy_commit: assert property ($changed(sysClkSel)
      |-> $past(switchBusy) ##[0:3] !switchBusy) else $error("bad commit");
   c_switch: cover property ($changed(sysClkSel));
   c_error: cover property (pready && pslverr);
   c_irq: cover property ($rose(irq));
   c_pll: cover property (pllEnable && pllLock);
endmodule
bind oss_sequencer oss_seq_props #(.NEW_CLK_CYCLES(NEW_CLK_CYCLES))
   oss_seq_props_i (.clk, .rst_n, .psel, .penable, .pwrite, .paddr, .prdata,
   .pready, .pslverr, .switchMonitorCfg, .pllLock, .newClkTick, .oscEnable,
   .pllEnable, .sysClkSel, .switchBusy, .irq);
`default_nettype wire

// *** bench/oss_sequencer_test.sv ***
// Self-checking bench of the oscillator switch sequencer.
`default_nettype none
`include "oss_defines.vh"
`define CHK(nm, e, g) begin compares++; \
   if ((g) !== (e)) begin error_cnt++; \
   $display("[ERR] %s exp %h got %h", nm, e, g); end end
module oss_sequencer_test;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk, rst_n, psel, penable, pwrite, pready, pslverr;
   logic switchMonitorCfg, primaryIsCrystal, pllLock, newClkTick;
   logic clockFailIn, watchdogUsesLprc, pllEnable, switchBusy, irq, errSeen;
   logic failSafeUsesLprc;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rdData;
   logic [3:0] pstrb, oscEnable;
   logic [2:0] sysClkSel;
   int error_cnt = 0;
   int compares = 0;
   oss_sequencer #(.OST_CYCLES(11'h004), .NEW_CLK_CYCLES(11'h00a))
   oss_sequencer_i (.clk, .rst_n, .ce(1'b1), .psel, .penable, .pwrite,
      .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .switchMonitorCfg,
      .cfgSourceSel(3'h0), .primaryIsCrystal, .pllLock, .newClkTick,
      .clockFailIn, .watchdogUsesLprc, .failSafeUsesLprc,
      .calendarUsesLprc(1'b0), .oscEnable, .pllEnable, .sysClkSel,
      .switchBusy, .irq);
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   // The new oscillator ticks every second cycle, slower than the bus.
   always @(posedge clk) begin
      newClkTick <= !newClkTick;
   end
   task automatic end_sim();
      $display("compares %0d error_cnt %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   // Read on the rising edge itself, before the design's updates land.
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d, input logic [3:0] s);
      int n;
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      pstrb <= s;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 64);
      if (pready !== 1'b1) begin
         error_cnt++;
         end_sim();
      end
      rdData = prdata;
      errSeen = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic unlock(input logic hi);
      apb(1'b1, `OSS_OFF_KEY, {24'h0, hi ? `OSS_KEY_HI1 : `OSS_KEY_LO1}, 4'h1);
      apb(1'b1, `OSS_OFF_KEY, {24'h0, hi ? `OSS_KEY_HI2 : `OSS_KEY_LO2}, 4'h1);
   endtask
   task automatic request(input logic [2:0] src);
      unlock(1'b1);
      apb(1'b1, `OSS_OFF_CTRL, {21'h0, src, 8'h00}, 4'h2);
      unlock(1'b0);
      apb(1'b1, `OSS_OFF_CTRL, 32'h1, 4'h1);
   endtask
   task automatic finish_sw(input logic [2:0] src, input logic [3:0] osc);
      int n;
      n = 0;
      do begin
         apb(1'b0, `OSS_OFF_CTRL, 32'h0, 4'h0);
         n++;
      end while (rdData[0] !== 1'b0 && n < 40);
      if (rdData[0] !== 1'b0) begin
         error_cnt++;
         end_sim();
      end
      `CHK("current", src, rdData[14:12])
      `CHK("sysClk", src, sysClkSel)
      `CHK("oscEn", osc, oscEnable)
   endtask
   initial begin
      rst_n = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      pstrb = 4'h0;
      switchMonitorCfg = 1'b1;
      primaryIsCrystal = 1'b1;
      pllLock = 1'b1;
      newClkTick = 1'b0;
      clockFailIn = 1'b0;
      watchdogUsesLprc = 1'b0;
      failSafeUsesLprc = 1'b0;
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk);
      `CHK("oscRst", 4'h4, oscEnable)
      apb(1'b0, `OSS_OFF_CTRL, 32'h0, 4'h0);
      `CHK("curRst", 3'h0, rdData[14:12])
      request(3'h4);
      apb(1'b0, `OSS_OFF_CTRL, 32'h0, 4'h0);
      `CHK("reqOff", 1'b0, rdData[0])
      `CHK("busyOff", 1'b0, switchBusy)
      switchMonitorCfg <= 1'b0;
      apb(1'b1, `OSS_OFF_CTRL, 32'h400, 4'h2);
      apb(1'b0, `OSS_OFF_CTRL, 32'h0, 4'h0);
      `CHK("nextLocked", 3'h0, rdData[10:8])
      apb(1'b0, 12'h020, 32'h0, 4'h0);
      `CHK("errBit", 1'b1, errSeen)
      `CHK("errData", 32'h0, rdData)
      apb(1'b1, `OSS_OFF_IEN, 32'h7, 4'hf);
      request(3'h0);
      finish_sw(3'h0, 4'h4);
      apb(1'b0, `OSS_OFF_STAT, 32'h0, 4'h0);
      `CHK("redund", 1'b1, rdData[`OSS_ST_REDUND])
      `CHK("irqOn", 1'b1, irq)
      apb(1'b1, `OSS_OFF_CLR, 32'h7, 4'hf);
      apb(1'b0, `OSS_OFF_STAT, 32'h0, 4'h0);
      `CHK("stClr", 3'h0, rdData[2:0])
      `CHK("irqOff", 1'b0, irq)
      apb(1'b1, `OSS_OFF_IEN, 32'h0, 4'hf);
      apb(1'b1, `OSS_OFF_CFG, 32'h1, 4'hf);
      request(3'h4);
      finish_sw(3'h4, 4'h2);
      apb(1'b0, `OSS_OFF_STAT, 32'h0, 4'h0);
      `CHK("done", 1'b1, rdData[`OSS_ST_DONE])
      `CHK("irqMask", 1'b0, irq)
      request(3'h0);
      finish_sw(3'h0, 4'h6);
      watchdogUsesLprc <= 1'b1;
      request(3'h5);
      finish_sw(3'h5, 4'ha);
      request(3'h0);
      finish_sw(3'h0, 4'he);
      pllLock <= 1'b0;
      @(posedge clk);
      clockFailIn <= 1'b1;
      @(posedge clk);
      clockFailIn <= 1'b0;
      apb(1'b0, `OSS_OFF_CTRL, 32'h0, 4'h0);
      `CHK("cfSet", 1'b1, rdData[`OSS_CF_BIT])
      request(3'h3);
      // Long enough for the start-up timer; the sequence then waits for the lock, before any ticks.
      repeat (60) @(posedge clk);
      apb(1'b0, `OSS_OFF_CTRL, 32'h0, 4'h0);
      `CHK("cfClr", 1'b0, rdData[`OSS_CF_BIT])
      `CHK("lockClr", 1'b0, rdData[`OSS_LOCK_BIT])
      `CHK("stall", 1'b1, switchBusy)
      pllLock <= 1'b1;
      finish_sw(3'h3, 4'hb);
      `CHK("lockSet", 1'b1, rdData[`OSS_LOCK_BIT])
      `CHK("pllOn", 1'b1, pllEnable)
      request(3'h0);
      finish_sw(3'h0, 4'he);
      `CHK("pllOff", 1'b0, pllEnable)
      request(3'h1);
      finish_sw(3'h1, 4'he);
      `CHK("fast_rc_with_pll_mode", 1'b1, pllEnable)
      watchdogUsesLprc <= 1'b0;
      failSafeUsesLprc <= 1'b1;
      request(3'h5);
      finish_sw(3'h5, 4'ha);
      request(3'h0);
      finish_sw(3'h0, 4'he);
      failSafeUsesLprc <= 1'b0;
      request(3'h5);
      finish_sw(3'h5, 4'ha);
      request(3'h0);
      finish_sw(3'h0, 4'h6);
      end_sim();
   end
endmodule
`default_nettype wire

// *** hw/oss_sequencer.v ***
// Oscillator switch sequencer with APB registers and interrupt.
`default_nettype none
`include "oss_defines.vh"
module oss_sequencer #(
   parameter [`OSS_TMR_W-1:0] OST_CYCLES = `OSS_OST_CYCLES,
   parameter [`OSS_TMR_W-1:0] NEW_CLK_CYCLES = `OSS_NEW_CLK_CYCLES
) (
   input wire clk,
   input wire rst_n,
   input wire ce,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [`OSS_ADDR_W-1:0] paddr,
   input wire [31:0] pwdata,
   input wire [3:0] pstrb,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   input wire switchMonitorCfg,
   input wire [2:0] cfgSourceSel,
   input wire primaryIsCrystal,
   input wire pllLock,
   input wire newClkTick,
   input wire clockFailIn,
   input wire watchdogUsesLprc,
   input wire failSafeUsesLprc,
   input wire calendarUsesLprc,
   output reg [3:0] oscEnable,
   output reg pllEnable,
   output reg [2:0] sysClkSel,
   output reg switchBusy,
   output reg irq
);
   localparam S_IDLE = 3'h0;
   localparam S_CHECK = 3'h1;
   localparam S_START = 3'h2;
   localparam S_OST = 3'h3;
   localparam S_PLL = 3'h4;
   localparam S_NEWCLK = 3'h5;
   localparam S_COMMIT = 3'h6;

   // Oscillator that a source code runs on.
   function [1:0] oscOf;
      input [2:0] src;
      begin
         case (src)
            `OSS_SRC_PRI: oscOf = `OSS_OSC_PRI;
            `OSS_SRC_PRIPLL: oscOf = `OSS_OSC_PRI;
            `OSS_SRC_SEC: oscOf = `OSS_OSC_SEC;
            `OSS_SRC_LOW_POWER_RC_OSC: oscOf = `OSS_OSC_LOW_POWER_RC_OSC;
            default: oscOf = `OSS_OSC_FRC;
         endcase
      end
   endfunction

   function usesPll;
      input [2:0] src;
      begin
         usesPll = src == `OSS_SRC_FAST_RC_WITH_PLL_MODE || src == `OSS_SRC_PRIPLL;
      end
   endfunction

   // One-hot power request for a single oscillator.
   function [3:0] oscBit;
      input [1:0] osc;
      begin
         oscBit = 4'h1 << osc;
      end
   endfunction

   // Committed bus write to one register through one byte lane.
   function laneWrite;
      input stb;
      input sel;
      input lane;
      begin
         laneWrite = stb && sel && lane;
      end
   endfunction

   // Reset leaves through two flops so all registers release together.
   reg rstMeta_reg;
   reg rstSync_reg;
   wire rstSync_n;
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rstMeta_reg <= 1'b0;
         rstSync_reg <= 1'b0;
      end else begin
         rstMeta_reg <= 1'b1;
         rstSync_reg <= rstMeta_reg;
      end
   end
   assign rstSync_n = rstSync_reg;

   reg [2:0] state_reg;
   reg [2:0] curSrc_reg;
   reg [2:0] nxtSrc_reg;
   reg [2:0] target_reg;
   reg switchReq_reg;
   reg lock_reg;
   reg clockFail_reg;
   reg secOscEn_reg;
   reg [3:0] oscRunning_reg;
   reg [`OSS_ST_W-1:0] status_reg;
   reg [`OSS_ST_W-1:0] irqEn_reg;

   wire switchingOn = !switchMonitorCfg;
   wire access = psel && penable && !pready;
   wire commit = psel && penable && pready;
   wire wrStb = commit && pwrite;
   wire selCtrl = paddr == `OSS_OFF_CTRL;
   wire selKey = paddr == `OSS_OFF_KEY;
   wire selStat = paddr == `OSS_OFF_STAT;
   wire selClr = paddr == `OSS_OFF_CLR;
   wire selIen = paddr == `OSS_OFF_IEN;
   wire selCfg = paddr == `OSS_OFF_CFG;
   wire mapped = selCtrl || selKey || selStat || selClr || selIen ||
      selCfg;
   wire armHigh;
   wire armLow;
   wire wrHigh = laneWrite(wrStb, selCtrl, pstrb[1]) && armHigh;
   wire wrLow = laneWrite(wrStb, selCtrl, pstrb[0]) && armLow;

   oss_unlock unlock (
      .clk(clk),
      .rstSync_n(rstSync_n),
      .ce(ce),
      .wrStb(wrStb),
      .wrKey(laneWrite(wrStb, selKey, pstrb[0])),
      .keyData(pwdata[7:0]),
      .armHigh(armHigh),
      .armLow(armLow)
   );

   // One timer serves both waits because they never overlap: the start-up
   // wait counts system cycles, the settle wait counts new-clock ticks.
   reg tmrLoad;
   reg [`OSS_TMR_W-1:0] tmrValue;
   wire tmrDone;
   wire tmrTick = state_reg == S_OST ? 1'b1 : newClkTick;
   oss_timer #(
      .W(`OSS_TMR_W)
   ) timer (
      .clk(clk),
      .rstSync_n(rstSync_n),
      .ce(ce),
      .load(tmrLoad),
      .loadValue(tmrValue),
      .tick(tmrTick),
      .done(tmrDone)
   );

   wire [1:0] newOsc = oscOf(target_reg);
   wire [1:0] oldOsc = oscOf(curSrc_reg);
   wire newIsCrystal = newOsc == `OSS_OSC_SEC ||
      (newOsc == `OSS_OSC_PRI && primaryIsCrystal);
   wire lprcNeeded = watchdogUsesLprc || failSafeUsesLprc ||
      calendarUsesLprc;
   // The old oscillator stays powered while something still needs it.
   wire keepOld = oldOsc == newOsc ||
      (oldOsc == `OSS_OSC_LOW_POWER_RC_OSC && lprcNeeded) ||
      (oldOsc == `OSS_OSC_SEC && secOscEn_reg);

   reg [2:0] state_next;
   reg redundant;
   reg switchStart;
   reg switchDone;
   always @* begin
      state_next = state_reg;
      redundant = 1'b0;
      switchStart = 1'b0;
      switchDone = 1'b0;
      tmrLoad = 1'b0;
      tmrValue = NEW_CLK_CYCLES;
      case (state_reg)
         S_IDLE: begin
            if (switchReq_reg && switchingOn)
               state_next = S_CHECK;
         end
         S_CHECK: begin
            if (nxtSrc_reg == curSrc_reg) begin
               redundant = 1'b1;
               state_next = S_IDLE;
            end else begin
               // Direct moves between the two PLL modes are not refused;
               // software has to pass through plain fast RC itself.
               switchStart = 1'b1;
               state_next = S_START;
            end
         end
         S_START: begin
            // A crystal already running, such as a secondary held on by
            // its enable, needs no second start-up wait.
            if (newIsCrystal && !oscRunning_reg[newOsc]) begin
               tmrLoad = 1'b1;
               tmrValue = OST_CYCLES;
               state_next = S_OST;
            end else begin
               state_next = S_PLL;
            end
         end
         S_OST: begin
            if (tmrDone)
               state_next = S_PLL;
         end
         S_PLL: begin
            if (!usesPll(target_reg) || lock_reg) begin
               tmrLoad = 1'b1;
               state_next = S_NEWCLK;
            end
         end
         S_NEWCLK: begin
            if (tmrDone)
               state_next = S_COMMIT;
         end
         S_COMMIT: begin
            switchDone = 1'b1;
            state_next = S_IDLE;
         end
         default: state_next = S_IDLE;
      endcase
   end

   wire [`OSS_ST_W-1:0] events = {clockFailIn, redundant, switchDone};
   wire [`OSS_ST_W-1:0] clrMask = laneWrite(wrStb, selClr, pstrb[0]) ?
      pwdata[`OSS_ST_W-1:0] : {`OSS_ST_W{1'b0}};
   wire [`OSS_ST_W-1:0] status_next = (status_reg & ~clrMask) | events;

   // The whole sequence runs in the background, so the bus keeps its
   // fixed two-cycle answer throughout a changeover.
   always @(posedge clk or negedge rstSync_n) begin
      if (!rstSync_n) begin
         state_reg <= S_IDLE;
         curSrc_reg <= `OSS_RST_SRC;
         nxtSrc_reg <= `OSS_RST_SRC;
         target_reg <= `OSS_RST_SRC;
         switchReq_reg <= 1'b0;
         lock_reg <= 1'b0;
         clockFail_reg <= 1'b0;
         secOscEn_reg <= 1'b0;
         oscRunning_reg <= `OSS_OSC_RST;
         oscEnable <= `OSS_OSC_RST;
         pllEnable <= 1'b0;
         sysClkSel <= `OSS_RST_SRC;
         switchBusy <= 1'b0;
         status_reg <= {`OSS_ST_W{1'b0}};
         irqEn_reg <= {`OSS_ST_W{1'b0}};
         irq <= 1'b0;
      end else if (ce) begin
         state_reg <= state_next;
         switchBusy <= state_next != S_IDLE;
         status_reg <= status_next;
         irq <= |(status_next & irqEn_reg);
         if (laneWrite(wrStb, selIen, pstrb[0]))
            irqEn_reg <= pwdata[`OSS_ST_W-1:0];
         if (laneWrite(wrStb, selCfg, pstrb[0]))
            secOscEn_reg <= pwdata[`OSS_SECEN_BIT];
         if (wrHigh && switchingOn)
            nxtSrc_reg <= pwdata[`OSS_NXT_HI:`OSS_NXT_LO];
         if (!switchingOn) begin
            switchReq_reg <= 1'b0;
            curSrc_reg <= cfgSourceSel;
            sysClkSel <= cfgSourceSel;
            // The configured source is the only one that has to run.
            oscEnable <= oscBit(oscOf(cfgSourceSel));
            oscRunning_reg <= oscBit(oscOf(cfgSourceSel));
            pllEnable <= usesPll(cfgSourceSel);
         end else if (redundant || switchDone) begin
            switchReq_reg <= 1'b0;
         end else if (wrLow && state_reg == S_IDLE) begin
            switchReq_reg <= pwdata[`OSS_REQ_BIT];
         end
         // A lock or clock-fail event in the start cycle still wins.
         if (switchStart)
            lock_reg <= 1'b0;
         if (pllEnable && pllLock)
            lock_reg <= 1'b1;
         else if (!pllEnable)
            lock_reg <= 1'b0;
         if (switchStart)
            clockFail_reg <= 1'b0;
         if (clockFailIn)
            clockFail_reg <= 1'b1;
         if (state_reg == S_CHECK && !redundant) begin
            target_reg <= nxtSrc_reg;
            oscEnable <= oscEnable | oscBit(oscOf(nxtSrc_reg));
            pllEnable <= pllEnable | usesPll(nxtSrc_reg);
         end
         if (state_reg == S_OST && tmrDone)
            oscRunning_reg <= oscRunning_reg | oscBit(newOsc);
         if (state_reg == S_START && !newIsCrystal)
            oscRunning_reg <= oscRunning_reg | oscBit(newOsc);
         if (switchDone) begin
            sysClkSel <= target_reg;
            curSrc_reg <= target_reg;
            pllEnable <= usesPll(target_reg);
            if (!keepOld) begin
               oscEnable <= oscEnable & ~oscBit(oldOsc);
               oscRunning_reg <= oscRunning_reg & ~oscBit(oldOsc);
            end
         end
      end
   end

   // The key and clear registers are write-only and read as zero.
   reg [31:0] readData;
   always @* begin
      readData = 32'h00000000;
      if (selCtrl) begin
         readData[`OSS_CUR_HI:`OSS_CUR_LO] = curSrc_reg;
         readData[`OSS_NXT_HI:`OSS_NXT_LO] = nxtSrc_reg;
         readData[`OSS_LOCK_BIT] = lock_reg;
         readData[`OSS_CF_BIT] = clockFail_reg;
         readData[`OSS_REQ_BIT] = switchReq_reg;
      end else if (selStat) begin
         readData[`OSS_ST_W-1:0] = status_reg;
      end else if (selIen) begin
         readData[`OSS_ST_W-1:0] = irqEn_reg;
      end else if (selCfg) begin
         readData[`OSS_SECEN_BIT] = secOscEn_reg;
      end
   end

   // One wait state keeps pready, prdata and pslverr all registered.
   always @(posedge clk or negedge rstSync_n) begin
      if (!rstSync_n) begin
         pready <= 1'b0;
         prdata <= 32'h00000000;
         pslverr <= 1'b0;
      end else if (ce) begin
         pready <= access;
         if (access) begin
            prdata <= pwrite ? 32'h00000000 : readData;
            pslverr <= !mapped;
         end else begin
            pslverr <= 1'b0;
         end
      end
   end
endmodule
`default_nettype wire

// *** hw/oss_timer.v ***
// Loadable down counter that advances on a tick and flags its expiry.
`default_nettype none
module oss_timer #(
   parameter W = 11
) (
   input wire clk,
   input wire rstSync_n,
   input wire ce,
   input wire load,
   input wire [W-1:0] loadValue,
   input wire tick,
   output reg done
);
   reg [W-1:0] count_reg;
   reg active_reg;
   always @(posedge clk or negedge rstSync_n) begin
      if (!rstSync_n) begin
         count_reg <= {W{1'b0}};
         active_reg <= 1'b0;
         done <= 1'b0;
      end else if (ce) begin
         if (load) begin
            count_reg <= loadValue;
            active_reg <= 1'b1;
            done <= 1'b0;
         end else if (active_reg && tick) begin
            count_reg <= count_reg - {{(W-1){1'b0}}, 1'b1};
            if (count_reg <= {{(W-1){1'b0}}, 1'b1}) begin
               active_reg <= 1'b0;
               done <= 1'b1;
            end
         end
      end
   end
endmodule
`default_nettype wire

// *** hw/oss_unlock.v ***
// Two-key unlock detector for the control register byte lanes.
`default_nettype none
`include "oss_defines.vh"
module oss_unlock (
   input wire clk,
   input wire rstSync_n,
   input wire ce,
   input wire wrStb,
   input wire wrKey,
   input wire [7:0] keyData,
   output reg armHigh,
   output reg armLow
);
   localparam S_NONE = 2'h0;
   localparam S_HI1 = 2'h1;
   localparam S_LO1 = 2'h2;
   reg [1:0] state_reg;
   reg [1:0] state_next;
   always @* begin
      state_next = S_NONE;
      case (state_reg)
         S_NONE: begin
            if (keyData == `OSS_KEY_HI1)
               state_next = S_HI1;
            else if (keyData == `OSS_KEY_LO1)
               state_next = S_LO1;
         end
         default: state_next = S_NONE;
      endcase
   end
   // Any committed write consumes a pending arm, so an unlock covers only
   // the write that follows it directly.
   always @(posedge clk or negedge rstSync_n) begin
      if (!rstSync_n) begin
         state_reg <= S_NONE;
         armHigh <= 1'b0;
         armLow <= 1'b0;
      end else if (ce && wrStb) begin
         state_reg <= wrKey ? state_next : S_NONE;
         armHigh <= wrKey && state_reg == S_HI1 &&
            keyData == `OSS_KEY_HI2;
         armLow <= wrKey && state_reg == S_LO1 &&
            keyData == `OSS_KEY_LO2;
      end
   end
endmodule
`default_nettype wire

// *** inc/oss_defines.vh ***
// Register map, field positions, codes and counts of the switch sequencer.
`ifndef OSS_DEFINES_VH
`define OSS_DEFINES_VH
`define OSS_ADDR_W 12
`define OSS_OFF_CTRL 12'h000
`define OSS_OFF_KEY 12'h004
`define OSS_OFF_STAT 12'h008
`define OSS_OFF_CLR 12'h00c
`define OSS_OFF_IEN 12'h010
`define OSS_OFF_CFG 12'h014
`define OSS_CUR_HI 14
`define OSS_CUR_LO 12
`define OSS_NXT_HI 10
`define OSS_NXT_LO 8
`define OSS_LOCK_BIT 5
`define OSS_CF_BIT 3
`define OSS_REQ_BIT 0
`define OSS_SECEN_BIT 0
`define OSS_ST_DONE 0
`define OSS_ST_REDUND 1
`define OSS_ST_CFAIL 2
`define OSS_ST_W 3
`define OSS_KEY_HI1 8'h78
`define OSS_KEY_HI2 8'h9a
`define OSS_KEY_LO1 8'h46
`define OSS_KEY_LO2 8'h57
`define OSS_SRC_FRC 3'h0
`define OSS_SRC_FAST_RC_WITH_PLL_MODE 3'h1
`define OSS_SRC_PRI 3'h2
`define OSS_SRC_PRIPLL 3'h3
`define OSS_SRC_SEC 3'h4
`define OSS_SRC_LOW_POWER_RC_OSC 3'h5
`define OSS_RST_SRC 3'h0
`define OSS_OSC_PRI 2'h0
`define OSS_OSC_SEC 2'h1
`define OSS_OSC_FRC 2'h2
`define OSS_OSC_LOW_POWER_RC_OSC 2'h3
`define OSS_OSC_RST 4'h4
`define OSS_TMR_W 11
`define OSS_OST_CYCLES 11'h400
`define OSS_NEW_CLK_CYCLES 11'h00a
`endif
